/* design/io_alloc_cfg.svh */
// Purpose: Offsets, reset values and digit codes of the signal allocation matrix
// Assumes: APB with 32-bit data, one aligned word per register
// Notes:   Definitions only
`ifndef IO_ALLOC_CFG_SVH
`define IO_ALLOC_CFG_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define OFS_FWD_SRC        12'h000
`define OFS_IN_SEL_B       12'h004
`define OFS_OUT_SEL_A      12'h008
`define OFS_OUT_SEL_B      12'h00C
`define OFS_NEAR_SEL       12'h010
`define OFS_DEC_LATCH_SEL  12'h014
`define OFS_POL_INV        12'h018
`define OFS_MODE           12'h01C
`define OFS_STATUS         12'h020

// ****************************************
// Reset values
// ****************************************
`define RST_FWD_SRC        16'h2100
`define RST_IN_SEL_B       16'h6548
`define RST_OUT_SEL_A      16'h0000
`define RST_OUT_SEL_B      16'h0100
`define RST_NEAR_SEL       16'h0000
`define RST_DEC_LATCH_SEL  16'h8888
`define RST_POL_INV        16'h0000
`define RST_MODE           2'h0

// ****************************************
// Digit codes
// ****************************************
`define DIG_PIN_LAST       4'h6
`define DIG_ON             4'h7
`define DIG_OFF            4'h8
`define DIG_INV_FIRST      4'h9
`define DIG_LATCH_MIN      4'h4
`define DIG_LATCH_INV_MIN  4'hD

`endif

/* design/io_alloc_pkg.sv */
// Purpose: Types shared by the signal allocation matrix
// Assumes: Nothing
// Notes:   Constants live in io_alloc_cfg.svh
package io_alloc_pkg;

   typedef enum logic [1:0]
   {
      MODE_POSITION = 2'b00,
      MODE_SPEED    = 2'b01,
      MODE_FORCE    = 2'b10
   } ctrl_mode_t;

   typedef struct packed
   {
      logic forward_travel_prohibit;
      logic reverse_travel_prohibit;
      logic forward_force_limit_in;
      logic reverse_force_limit_in;
      logic homing_slowdown_in;
      logic latch_input_one;
      logic latch_input_two;
      logic latch_input_three;
   } in_func_t;

   typedef struct packed
   {
      logic position_done_out;
      logic speed_match_out;
      logic motion_detect_out;
      logic servo_ready_out;
      logic force_limited_out;
      logic speed_limited_out;
      logic holding_brake_out;
      logic warning_out;
      logic near_out;
   } out_func_t;

endpackage : io_alloc_pkg

/* design/input_route.sv */
// Purpose: One input function chosen from the seven input pins by one digit
// Assumes: Pins are ordered 13, 7, 8, 9, 10, 11, 12 on bits 0..6
// Notes:   Latch variant refuses the first four pins
`include "io_alloc_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module input_route #(
   parameter bit LATCH_ONLY = 1'b0
)
(
   // Selection
   input  wire logic [3:0] digit,
   // Pins
   input  wire logic [6:0] pins,
   // Function level
   output logic            func
);

   logic [2:0] idx;
   logic       pin_lvl;
   logic       legal;

   always_comb
   begin
      if (digit >= `DIG_INV_FIRST)
      begin
         idx = 3'(digit - `DIG_INV_FIRST);
      end
      else
      begin
         idx = digit[2:0];
      end
      pin_lvl = (idx == 3'd7) ? 1'b0 : pins[idx];
      legal   = 1'b1;
      if (LATCH_ONLY)
      begin
         legal = (digit >= `DIG_LATCH_MIN && digit <= `DIG_OFF) ||
                 (digit >= `DIG_LATCH_INV_MIN);
      end
      if (!legal)
      begin
         func = 1'b0;
      end
      else if (digit == `DIG_ON)
      begin
         func = 1'b1;
      end
      else if (digit == `DIG_OFF)
      begin
         func = 1'b0;
      end
      else if (digit <= `DIG_PIN_LAST)
      begin
         func = pin_lvl;
      end
      else
      begin
         func = ~pin_lvl;
      end
   end

endmodule : input_route

`default_nettype wire

/* design/io_signal_allocation_matrix.sv */
// Purpose: Routes sequence input pins to input functions and status functions to output pairs
// Assumes: APB slave on pclk; pins synchronous to pclk
// Notes:   Routing is combinational from the setting registers
// How it works
// - Digits 0-6 route a function from pins 13,7..12 at its primary level.
// - Digits 9-F route from the same pins with the opposite level.
// - Digit 7 holds the function asserted, digit 8 deasserted.
// - Latch inputs accept only pins 10-12; other pin selections give inactive.
// - One pin feeds every function mapped onto it at once.
// - Output setting 1,2,3 drives pair one,two,three; 0 leaves unconnected.
// - Several functions on one pair are ORed together.
// - Functions meaningless in the present control mode are treated inactive.
// - Per-pair invert bit flips that pair; reset leaves all non-inverted.
//
// Chosen here: the register addresses and the APB slave port.
`include "io_alloc_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module io_signal_allocation_matrix
   import io_alloc_pkg::*;
(
   // Clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // Sequence input pins, bit 0 = pin 13, bits 1..6 = pins 7..12
   input  wire logic [6:0]  seq_in_pins,
   // Internal status functions
   input  wire out_func_t   status_func,
   // Routed input functions
   output in_func_t         in_func,
   // Output pairs, bit 0 = pins 1/2, bit 1 = 23/24, bit 2 = 25/26
   output logic [2:0]       seq_out_pairs
);

   // ****************************************
   // Setting registers
   // ****************************************
   logic [15:0] fwd_src_q;
   logic [15:0] in_sel_b_q;
   logic [15:0] out_sel_a_q;
   logic [15:0] out_sel_b_q;
   logic [15:0] near_sel_q;
   logic [15:0] dec_latch_sel_q;
   logic [15:0] pol_inv_q;
   ctrl_mode_t  mode_q;

   logic        wr_en;
   logic        addr_ok;
   logic [31:0] rd_d;
   logic [31:0] wmask;
   logic [7:0]  wr_hit;

   assign wr_en   = psel && penable && pwrite;
   assign pready  = 1'b1;

   always_comb
   begin
      wmask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
   end

   function automatic logic [15:0] merge16(input logic [15:0] old,
                                           input logic [31:0] wd,
                                           input logic [31:0] m);
      merge16 = (old & ~m[15:0]) | (wd[15:0] & m[15:0]);
   endfunction : merge16

   // ****************************************
   // Write decode, one strobe per register
   // ****************************************
   always_comb
   begin
      // Unmapped writes raise no strobe
      wr_hit = 8'h00;
      case (paddr)
         `OFS_FWD_SRC:       wr_hit[0] = wr_en;
         `OFS_IN_SEL_B:      wr_hit[1] = wr_en;
         `OFS_OUT_SEL_A:     wr_hit[2] = wr_en;
         `OFS_OUT_SEL_B:     wr_hit[3] = wr_en;
         `OFS_NEAR_SEL:      wr_hit[4] = wr_en;
         `OFS_DEC_LATCH_SEL: wr_hit[5] = wr_en;
         `OFS_POL_INV:       wr_hit[6] = wr_en;
         `OFS_MODE:          wr_hit[7] = wr_en;
         default:
         begin
         end
      endcase
   end

   // ****************************************
   // Register write ports
   // ****************************************
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         fwd_src_q <= `RST_FWD_SRC;
      end
      else if (wr_hit[0])
      begin
         fwd_src_q <= merge16(fwd_src_q, pwdata, wmask);
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         in_sel_b_q <= `RST_IN_SEL_B;
      end
      else if (wr_hit[1])
      begin
         in_sel_b_q <= merge16(in_sel_b_q, pwdata, wmask);
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         out_sel_a_q <= `RST_OUT_SEL_A;
      end
      else if (wr_hit[2])
      begin
         out_sel_a_q <= merge16(out_sel_a_q, pwdata, wmask);
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         out_sel_b_q <= `RST_OUT_SEL_B;
      end
      else if (wr_hit[3])
      begin
         out_sel_b_q <= merge16(out_sel_b_q, pwdata, wmask);
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         near_sel_q <= `RST_NEAR_SEL;
      end
      else if (wr_hit[4])
      begin
         near_sel_q <= merge16(near_sel_q, pwdata, wmask);
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         dec_latch_sel_q <= `RST_DEC_LATCH_SEL;
      end
      else if (wr_hit[5])
      begin
         dec_latch_sel_q <= merge16(dec_latch_sel_q, pwdata, wmask);
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pol_inv_q <= `RST_POL_INV;
      end
      else if (wr_hit[6])
      begin
         pol_inv_q <= merge16(pol_inv_q, pwdata, wmask);
      end
   end

   // Code 3 names no mode and is ignored
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         mode_q <= MODE_POSITION;
      end
      else if (wr_hit[7] && pstrb[0] && pwdata[1:0] != 2'b11)
      begin
         mode_q <= ctrl_mode_t'(pwdata[1:0]);
      end
   end

   // ****************************************
   // Read mux and error answer
   // ****************************************
   always_comb
   begin
      addr_ok = 1'b1;
      rd_d    = 32'h0000_0000;
      case (paddr)
         `OFS_FWD_SRC:       rd_d[15:0] = fwd_src_q;
         `OFS_IN_SEL_B:      rd_d[15:0] = in_sel_b_q;
         `OFS_OUT_SEL_A:     rd_d[15:0] = out_sel_a_q;
         `OFS_OUT_SEL_B:     rd_d[15:0] = out_sel_b_q;
         `OFS_NEAR_SEL:      rd_d[15:0] = near_sel_q;
         `OFS_DEC_LATCH_SEL: rd_d[15:0] = dec_latch_sel_q;
         `OFS_POL_INV:       rd_d[15:0] = pol_inv_q;
         `OFS_MODE:          rd_d[1:0]  = mode_q;
         `OFS_STATUS:        rd_d[18:0] = {seq_out_pairs, seq_in_pins, in_func, 1'b0};
         default:            addr_ok    = 1'b0;
      endcase
   end

   assign pslverr = psel && penable && !addr_ok;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata <= 32'h0000_0000;
      end
      else if (psel && !penable && !pwrite)
      begin
         prdata <= rd_d;
      end
   end

   // ****************************************
   // Input routing, one instance per function
   // ****************************************
   logic [7:0][3:0] in_digit;
   logic [7:0]      in_lvl;

   assign in_digit[7] = fwd_src_q[15:12];
   assign in_digit[6] = in_sel_b_q[3:0];
   assign in_digit[5] = in_sel_b_q[11:8];
   assign in_digit[4] = in_sel_b_q[15:12];
   assign in_digit[3] = dec_latch_sel_q[3:0];
   assign in_digit[2] = dec_latch_sel_q[7:4];
   assign in_digit[1] = dec_latch_sel_q[11:8];
   assign in_digit[0] = dec_latch_sel_q[15:12];

   // Every function sees the same pin vector
   genvar gi;
   generate
      for (gi = 0; gi < 8; gi++)
      begin : g_in
         input_route #(
            .LATCH_ONLY (gi < 3)
         ) u_route (
            .digit (in_digit[gi]),
            .pins  (seq_in_pins),
            .func  (in_lvl[gi])
         );
      end
   endgenerate

   assign in_func = in_func_t'(in_lvl);

   // ****************************************
   // Output routing
   // ****************************************
   logic [8:0][1:0] out_sel;
   out_func_t       mode_ok;
   logic [8:0]      eff_v;
   logic [2:0]      merged;

   assign out_sel[8] = out_sel_a_q[1:0];
   assign out_sel[7] = out_sel_a_q[5:4];
   assign out_sel[6] = out_sel_a_q[9:8];
   assign out_sel[5] = out_sel_a_q[13:12];
   assign out_sel[4] = out_sel_b_q[1:0];
   assign out_sel[3] = out_sel_b_q[5:4];
   assign out_sel[2] = out_sel_b_q[9:8];
   assign out_sel[1] = out_sel_b_q[13:12];
   assign out_sel[0] = near_sel_q[1:0];

   // ****************************************
   // Functions valid in the present control mode
   // ****************************************
   always_comb
   begin
      mode_ok = '1;
      case (mode_q)
         MODE_POSITION:
         begin
            mode_ok.speed_match_out   = 1'b0;
            mode_ok.speed_limited_out = 1'b0;
         end
         MODE_SPEED:
         begin
            mode_ok.position_done_out = 1'b0;
            mode_ok.near_out          = 1'b0;
            mode_ok.speed_limited_out = 1'b0;
         end
         MODE_FORCE:
         begin
            mode_ok.position_done_out = 1'b0;
            mode_ok.near_out          = 1'b0;
            mode_ok.speed_match_out   = 1'b0;
         end
         default:
         begin
            mode_ok.position_done_out = 1'b0;
            mode_ok.near_out          = 1'b0;
            mode_ok.speed_match_out   = 1'b0;
            mode_ok.speed_limited_out = 1'b0;
         end
      endcase
   end

   assign eff_v = status_func & mode_ok;

   // ****************************************
   // Per-pair OR merge
   // ****************************************
   // Pair p gathers every function whose select is p + 1
   genvar gp;
   generate
      for (gp = 0; gp < 3; gp++)
      begin : g_pair
         logic [8:0] hit;
         always_comb
         begin
            for (int k = 0; k < 9; k++)
            begin
               hit[k] = (out_sel[k] == 2'(gp + 1)) && eff_v[k];
            end
         end
         assign merged[gp] = |hit;
      end
   endgenerate

   assign seq_out_pairs = merged ^ pol_inv_q[2:0];

endmodule : io_signal_allocation_matrix

`default_nettype wire

/* tb/alloc_chk.sv */
// Purpose: Port-level checks of the allocation matrix
// Assumes: APB writes honour the two low byte strobes
// Notes:   Bound to the top module
`include "io_alloc_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module alloc_chk
   import io_alloc_pkg::*;
(
   // Clock and reset
   input wire logic        pclk,
   input wire logic        presetn,
   // APB
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0]  pstrb,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   // Pins and functions
   input wire logic [6:0]  seq_in_pins,
   input wire out_func_t   status_func,
   input wire in_func_t    in_func,
   input wire logic [2:0]  seq_out_pairs
);
   logic [15:0] lat_q;
   logic [2:0]  inv_q;
   wire logic   wr = psel && penable && pwrite && pready;
   // ****
   // Shadow settings
   // ****
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn) lat_q <= `RST_DEC_LATCH_SEL;
      else if (wr && paddr == `OFS_DEC_LATCH_SEL)
      begin
         if (pstrb[0]) lat_q[7:0] <= pwdata[7:0];
         if (pstrb[1]) lat_q[15:8] <= pwdata[15:8];
      end
   end
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn) inv_q <= 3'h0;
      else if (wr && paddr == `OFS_POL_INV && pstrb[0]) inv_q <= pwdata[2:0];
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   AST_READY: assert property (psel && penable |-> pready)
      else $error("pready low");
   AST_ERR: assert property (psel && penable
      |-> pslverr == (paddr > `OFS_STATUS || paddr[1:0] != 2'b00))
      else $error("pslverr wrong");
   AST_RD0: assert property (psel && penable && !pwrite && paddr > `OFS_STATUS
      |-> prdata == 32'h0000_0000)
      else $error("unmapped read not zero");
   AST_LAT_PIN: assert property (lat_q[7:4] inside {[4'h4:4'h6]}
      |-> in_func.latch_input_one == seq_in_pins[lat_q[7:4]])
      else $error("latch pin level");
   AST_LAT_INV: assert property (lat_q[7:4] >= 4'hD
      |-> in_func.latch_input_one == !seq_in_pins[lat_q[7:4] - 4'h9])
      else $error("latch inverted level");
   AST_LAT_BAD: assert property (lat_q[11:8] < 4'h4 || lat_q[11:8] inside {[4'h9:4'hC]}
      |-> !in_func.latch_input_two)
      else $error("latch bad pin");
   AST_ON: assert property (lat_q[15:12] == 4'h7 |-> in_func.latch_input_three)
      else $error("always on");
   AST_OFF: assert property (lat_q[3:0] == 4'h8 |-> !in_func.homing_slowdown_in)
      else $error("always off");
   AST_INV: assert property (status_func == '0 |-> seq_out_pairs == inv_q)
      else $error("pair polarity");
   cover property (wr && paddr == `OFS_POL_INV);
   cover property (psel && penable && pslverr);
   cover property (lat_q[7:4] >= 4'hD);
endmodule : alloc_chk
bind io_signal_allocation_matrix alloc_chk alloc_chk_i (.pclk, .presetn, .psel, .penable,
   .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .seq_in_pins,
   .status_func, .in_func, .seq_out_pairs);
`default_nettype wire

/* tb/host_io_model.sv */
// Purpose: Host sequence lines driving the input pins
// Assumes: Levels change only after a clock edge
// Notes:   Bench chooses the levels
`timescale 1ns/1ps
`default_nettype none
module host_io_model
(
   // Clock
   input  wire logic       pclk,
   // Levels asked by the bench
   input  wire logic [6:0] drv,
   // Lines toward the device
   output logic [6:0]      seq_in_pins
);
   always @(posedge pclk) seq_in_pins <= drv;
endmodule : host_io_model
`default_nettype wire

/* tb/io_signal_allocation_matrix_tb_top.sv */
// Purpose: Self-checking bench of the allocation matrix
// Assumes: Zero-wait APB, byte strobes on writes
// Notes:   Model in m[] mirrors the settings
`include "io_alloc_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module io_signal_allocation_matrix_tb_top
   import io_alloc_pkg::*;
();
   logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, r, v;
   logic [3:0]  pstrb = 4'hF;
   logic        pready, pslverr;
   logic [6:0]  drv = '0, seq_in_pins;
   out_func_t   status_func = '0;
   in_func_t    in_func;
   logic [2:0]  seq_out_pairs;
   logic [15:0] m[8];
   int          bad_count = 0, total_checks = 0, cyc = 0, i, d, it;
   localparam logic [15:0] MK[8] = '{16'hFFFF, 16'hFFFF, 16'h3333, 16'h3333,
                                     16'h0003, 16'hFFFF, 16'h0007, 16'h0003};
   io_signal_allocation_matrix io_signal_allocation_matrix_i (.pclk, .presetn, .psel,
      .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
      .seq_in_pins, .status_func, .in_func, .seq_out_pairs);
   host_io_model host_io_model_i (.pclk, .drv, .seq_in_pins);
   always #4 pclk = ~pclk;
   // ****
   // Model and tasks
   // ****
   function automatic logic dg(logic [3:0] v, bit l, logic [6:0] p);
      if (v == 4'h7) return 1'b1;
      if (v == 4'h8) return 1'b0;
      if (l && (v < 4'h4 || (v > 4'h8 && v < 4'hD))) return 1'b0;
      return v < 4'h7 ? p[v] : !p[v - 4'h9];
   endfunction : dg
   function automatic logic [7:0] ein(logic [6:0] p);
      return {dg(m[0][15:12], 0, p), dg(m[1][3:0], 0, p), dg(m[1][11:8], 0, p),
              dg(m[1][15:12], 0, p), dg(m[5][3:0], 0, p), dg(m[5][7:4], 1, p),
              dg(m[5][11:8], 1, p), dg(m[5][15:12], 1, p)};
   endfunction : ein
   function automatic logic [2:0] eout(logic [8:0] s);
      logic [2:0] o;
      logic [1:0] sl;
      o = 3'h0;
      for (int k = 0; k < 9; k++)
      begin
         sl = k < 4 ? m[2][4*k+:2] : k < 8 ? m[3][4*(k-4)+:2] : m[4][1:0];
         if ((k == 0 || k == 8) && m[7] != 0 || k == 1 && m[7] != 1 || k == 5 && m[7] != 2)
            s[8-k] = 1'b0;
         if (sl != 0 && s[8-k]) o[sl-1] = 1'b1;
      end
      return o ^ m[6][2:0];
   endfunction : eout
   task automatic cmp(string n, logic [31:0] e, logic [31:0] s);
      total_checks++;
      if (e !== s)
      begin
         bad_count++;
         $display("ERROR %s exp %h got %h", n, e, s);
      end
   endtask : cmp
   task automatic apb(bit w, int a, logic [31:0] dt, logic [3:0] st);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a[11:0];
      pwdata <= dt;
      pstrb <= st;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      r = prdata;
      cmp("pslverr", a > 32, pslverr);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic wr(int k, logic [31:0] dt, logic [3:0] st);
      logic [15:0] bm;
      bm = {{8{st[1]}}, {8{st[0]}}};
      apb(1, 4 * k, dt, st);
      if (k == 7)
      begin
         if (st[0] && dt[1:0] != 2'h3) m[7] = 16'(dt[1:0]);
      end
      else if (k < 7) m[k] = (m[k] & ~bm | dt[15:0] & bm) & MK[k];
   endtask : wr
   task automatic rd(int k);
      apb(0, 4 * k, 0, 4'h0);
      if (k < 8) cmp("reg", m[k], r & MK[k]);
      else if (k == 8) cmp("status", {eout(status_func), seq_in_pins, ein(seq_in_pins), 1'b0}, r);
      else cmp("unmapped", 0, r);
   endtask : rd
   task automatic stim(logic [8:0] s);
      @(posedge pclk);
      drv <= 7'($urandom);
      status_func <= s;
      repeat (2) @(posedge pclk);
      @(negedge pclk);
      cmp("in_func", ein(seq_in_pins), in_func);
      cmp("pairs", eout(status_func), seq_out_pairs);
   endtask : stim
   task automatic complete_run();
      if (bad_count == 0 && total_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : complete_run
   always @(posedge pclk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         bad_count++;
         complete_run();
      end
   end
   // ****
   // Main sequence
   // ****
   initial
   begin
      void'($urandom(32'h1c46));
      m = '{`RST_FWD_SRC, `RST_IN_SEL_B, `RST_OUT_SEL_A, `RST_OUT_SEL_B, `RST_NEAR_SEL,
            `RST_DEC_LATCH_SEL, `RST_POL_INV, 16'h0000};
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      // Overtravel and brake still at safe polarity here
      for (i = 0; i < 10; i++) rd(i);
      stim(9'($urandom));
      for (d = 0; d < 16; d++)
      begin
         wr(0, (d > 8 ? d - 9 : d) << 12, 4'hF);
         wr(1, {{3{d[3:0]}}, d > 8 ? 4'(d - 9) : d[3:0]}, 4'hF);
         wr(5, {4{d[3:0]}}, 4'hF);
         repeat (3) stim(9'h000);
      end
      for (it = 0; it < 200; it++)
      begin
         i = $urandom % 9;
         v = $urandom;
         if (i == 0) v[15] = 1'b0;
         if (i == 1) v[3] = 1'b0;
         if (i == 3) v[9:8] = 2'h0;
         if (i == 6 && m[3][9:8] != 0) v[m[3][9:8] - 1] = 1'b0;
         wr(i == 8 ? 9 : i, v, 4'($urandom));
         stim(9'($urandom) & {9{it[0]}});
         rd(8);
      end
      complete_run();
   end
endmodule : io_signal_allocation_matrix_tb_top
`default_nettype wire
